// ==== design/tasl_cfg.svh ====
// offsets, field positions, reset values and timing counts of the alarm block
`ifndef TASL_CFG_SVH
`define TASL_CFG_SVH
// register offsets; 00h to 02h are read only, 0Fh is write only, the rest read and write alike
`define TASL_A_LOCT     8'h00
`define TASL_A_REMT     8'h01
`define TASL_A_STAT     8'h02
`define TASL_A_CFG      8'h09
`define TASL_A_LHI      8'h0b
`define TASL_A_LLO      8'h0c
`define TASL_A_RHI      8'h0d
`define TASL_A_RLO      8'h0e
`define TASL_A_ONESHOT  8'h0f
`define TASL_A_RTHERM   8'h19
`define TASL_A_LTHERM   8'h20
`define TASL_A_HYST     8'h21
// configuration fields
`define TASL_CFG_STBY   6
`define TASL_CFG_MASK   7
// status fields
`define TASL_ST_BUSY    7
`define TASL_ST_LHI     6
`define TASL_ST_LLO     5
`define TASL_ST_RHI     4
`define TASL_ST_RLO     3
`define TASL_ST_OPEN    2
`define TASL_ST_LTH     1
`define TASL_ST_RTH     0
// reset values, below-range remote code and device address
`define TASL_RST_CFG    8'h00
`define TASL_RST_HI     8'h55
`define TASL_RST_LO     8'h00
`define TASL_RST_OVERTEMP_FAILSAFE_OUT  8'h55
`define TASL_RST_HYST   8'h0a
`define TASL_SHORT_CODE 8'h80
`define TASL_DEV_ADDR   7'h4c
// idle cycles between back-to-back conversions
`define TASL_GAP_CYC    16'h0100
`endif

// ==== design/tasl_pkg.sv ====
// types of the alarm and standby block
package tasl_pkg;
    typedef enum logic [1:0] {C_IDLE, C_CONV, C_GAP} tasl_conv_t;
endpackage

// ==== design/tasl_top.sv ====
// alarm, fail-safe and standby logic of a two-channel temperature monitor
`timescale 1ns/10ps
`include "tasl_cfg.svh"

// Overview of operation
// - Alert pulls low on any out-of-limit reading or open remote sensor.
// - Alert only drives low or releases, for wired-OR sharing.
// - While alerting, answer the response address with own address plus one.
// - Bit arbitration during the answer lets the lowest address win.
// - After a won answer, release alert only if its cause cleared.
// - Configuration bit 6 set means standby, clear means normal running.
// - Standby stops the converter and aborts conversions without storing.
// - Register reads and writes keep working during standby.
// - Any write to 0Fh runs one conversion, then standby resumes.
// - Limit writes in standby apply and may raise alert from stored values.
// - Alert is maskable; the over-temperature output never is.
// - Low limit compares less-than-or-equal.
// - Either channel strictly above its high limit raises alert.
// - No alert is raised while both readings lie inside their limits and no open sensor is flagged.
// - Separate local and remote over-temperature limits drive the fail-safe.
// - One hysteresis value, reset to 10 degrees, serves both channels.
// - Open detector sampled at each conversion start sets status bit 2.
// - Remote input below range is stored as -128.
// - A -128 remote reading always trips the low compare and raises alert unless masked.
module tasl_top #(
    parameter logic [15:0] GAP_CYC  = `TASL_GAP_CYC,
    parameter logic [6:0]  DEV_ADDR = `TASL_DEV_ADDR
) (
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    input  wire logic       LINK_CLK,
    input  wire logic       WR_STB,
    input  wire logic [7:0] WR_ADDR,
    input  wire logic [7:0] WR_DATA,
    input  wire logic       RD_STB,
    input  wire logic [7:0] RD_ADDR,
    output logic      [7:0] RD_DATA,
    output logic            RD_VALID,
    output logic            ARA_ACK,
    input  wire logic       ARA_LOAD,
    input  wire logic       ARA_BIT_STB,
    input  wire logic       ARA_SDA_BIT,
    input  wire logic       ARA_END,
    output logic            ARA_SDA_O,
    output logic            ARA_SDA_OE,
    output logic            CONV_START,
    output logic            CONV_ABORT,
    input  wire logic       CONV_DONE,
    input  wire logic [7:0] CONV_LOCAL,
    input  wire logic [7:0] CONV_REMOTE,
    input  wire logic       REMOTE_UNDER,
    input  wire logic       OPEN_DET,
    input  wire logic       ALERT_I,
    output logic            ALERT_O,
    output logic            ALERT_OE,
    input  wire logic       OVERTEMP_FAILSAFE_OUT_I,
    output logic            OVERTEMP_FAILSAFE_OUT_O,
    output logic            OVERTEMP_FAILSAFE_OUT_OE
);
    // ***************************************************************
    // link domain: register access capture and alert response
    // ***************************************************************
    logic [7:0] wa, wd, ra, rd_hold;
    logic [7:0] next_wa, next_wd, next_ra, next_rd_data, next_sh, sh;
    logic       wtog, rtog, atog, act, lost, rdack;
    logic       next_wtog, next_rtog, next_atog, next_act, next_lost;
    logic       next_rd_valid, next_sda_oe;
    logic       al_s1, rk_s1, rk_s2, rk_s3;

    always_comb begin
        next_wa = wa;
        next_wd = wd;
        next_wtog = wtog;
        next_ra = ra;
        next_rtog = rtog;
        next_sh = sh;
        next_act = act;
        next_lost = lost;
        next_atog = atog;
        // words are held stable until the toggle has crossed
        if (WR_STB) begin
            next_wa = WR_ADDR;
            next_wd = WR_DATA;
            next_wtog = ~wtog;
        end
        if (RD_STB) begin
            next_ra = RD_ADDR;
            next_rtog = ~rtog;
        end
        next_rd_valid = rk_s2 ^ rk_s3;
        next_rd_data = next_rd_valid ? rd_hold : RD_DATA;
        if (ARA_LOAD && ARA_ACK) begin
            next_sh = {DEV_ADDR, 1'b1};
            next_act = 1'b1;
            next_lost = 1'b0;
        end else if (ARA_BIT_STB && act) begin
            // a one sent while the bus reads zero loses the arbitration
            if (sh[7] && !ARA_SDA_BIT) begin
                next_lost = 1'b1;
            end
            next_sh = {sh[6:0], 1'b1};
        end
        if (ARA_END) begin
            if (act && !lost) begin
                next_atog = ~atog;
            end
            next_act = 1'b0;
        end
        next_sda_oe = next_act && !next_lost && !next_sh[7];
    end

    always_ff @(posedge LINK_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wa <= 8'h00;
            wd <= 8'h00;
            wtog <= 1'b0;
            ra <= 8'h00;
            rtog <= 1'b0;
            sh <= 8'hff;
            act <= 1'b0;
            lost <= 1'b0;
            atog <= 1'b0;
            RD_DATA <= 8'h00;
            RD_VALID <= 1'b0;
            ARA_SDA_OE <= 1'b0;
            ARA_SDA_O <= 1'b0;
            al_s1 <= 1'b0;
            ARA_ACK <= 1'b0;
            rk_s1 <= 1'b0;
            rk_s2 <= 1'b0;
            rk_s3 <= 1'b0;
        end else begin
            wa <= next_wa;
            wd <= next_wd;
            wtog <= next_wtog;
            ra <= next_ra;
            rtog <= next_rtog;
            sh <= next_sh;
            act <= next_act;
            lost <= next_lost;
            atog <= next_atog;
            RD_DATA <= next_rd_data;
            RD_VALID <= next_rd_valid;
            ARA_SDA_OE <= next_sda_oe;
            ARA_SDA_O <= 1'b0;
            al_s1 <= ALERT_OE;
            ARA_ACK <= al_s1;
            rk_s1 <= rdack;
            rk_s2 <= rk_s1;
            rk_s3 <= rk_s2;
        end
    end

    AST_ARA_BYTE: assert property (@(posedge LINK_CLK) disable iff (SYS_RST)
        ARA_LOAD && ARA_ACK |=> sh == {DEV_ADDR, 1'b1})
        else $error("alert answer byte is not own address plus one");
    AST_ARB_LOST: assert property (@(posedge LINK_CLK) disable iff (SYS_RST)
        lost |-> !ARA_SDA_OE)
        else $error("data line driven after arbitration loss");

    // ***************************************************************
    // crossings into the system domain
    // ***************************************************************
    logic ws1, ws2, ws3, rs1, rs2, rs3, as1, as2, as3, os1, os2;

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            {ws1, ws2, ws3} <= 3'h0;
            {rs1, rs2, rs3} <= 3'h0;
            {as1, as2, as3} <= 3'h0;
            {os1, os2} <= 2'h0;
        end else begin
            {ws1, ws2, ws3} <= {wtog, ws1, ws2};
            {rs1, rs2, rs3} <= {rtog, rs1, rs2};
            {as1, as2, as3} <= {atog, as1, as2};
            {os1, os2} <= {OPEN_DET, os1};
        end
    end

    logic wr_hit, rd_hit, ara_hit;
    assign wr_hit = ws2 ^ ws3;
    assign rd_hit = rs2 ^ rs3;
    assign ara_hit = as2 ^ as3;

    // ***************************************************************
    // conversion control
    // ***************************************************************
    tasl_pkg::tasl_conv_t st, next_st;
    logic [7:0]        cfg;
    logic signed [7:0] loc_t, rem_t, next_loc, next_rem;
    logic [15:0]       gap, next_gap;
    logic              os_req, os_run, open_f, seen, stby, wr_os;
    logic              next_os_req, next_os_run, next_open, next_seen;
    logic              next_start, next_abort;

    assign stby = cfg[`TASL_CFG_STBY];
    assign wr_os = wr_hit && wa == `TASL_A_ONESHOT;

    always_comb begin
        next_st = st;
        next_gap = gap;
        next_loc = loc_t;
        next_rem = rem_t;
        next_seen = seen;
        next_open = open_f;
        next_os_run = os_run;
        next_os_req = os_req | wr_os;
        next_start = 1'b0;
        next_abort = 1'b0;
        unique case (st)
            tasl_pkg::C_IDLE: begin
                if (!stby || os_req) begin
                    next_start = 1'b1;
                    next_st = tasl_pkg::C_CONV;
                    next_os_run = stby;
                    next_open = os2;
                    next_os_req = wr_os;
                end
            end
            tasl_pkg::C_CONV: begin
                // abort wins over a result in the same cycle
                if (stby && !os_run) begin
                    next_abort = 1'b1;
                    next_st = tasl_pkg::C_IDLE;
                end else if (CONV_DONE) begin
                    next_loc = CONV_LOCAL;
                    next_rem = REMOTE_UNDER ? `TASL_SHORT_CODE : CONV_REMOTE;
                    next_seen = 1'b1;
                    next_os_run = 1'b0;
                    next_gap = GAP_CYC;
                    next_st = tasl_pkg::C_GAP;
                end
            end
            tasl_pkg::C_GAP: begin
                if (gap == 16'h0000 || stby) begin
                    next_st = tasl_pkg::C_IDLE;
                end else begin
                    next_gap = gap - 16'h0001;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st <= tasl_pkg::C_IDLE;
            gap <= 16'h0000;
            loc_t <= 8'sh00;
            rem_t <= 8'sh00;
            seen <= 1'b0;
            open_f <= 1'b0;
            os_run <= 1'b0;
            os_req <= 1'b0;
            CONV_START <= 1'b0;
            CONV_ABORT <= 1'b0;
        end else begin
            st <= next_st;
            gap <= next_gap;
            loc_t <= next_loc;
            rem_t <= next_rem;
            seen <= next_seen;
            open_f <= next_open;
            os_run <= next_os_run;
            os_req <= next_os_req;
            CONV_START <= next_start;
            CONV_ABORT <= next_abort;
        end
    end

    AST_ABORT: assert property (@(posedge CLK) disable iff (SYS_RST)
        st == tasl_pkg::C_CONV && stby && !os_run |=> CONV_ABORT && st == tasl_pkg::C_IDLE)
        else $error("conversion not aborted on standby");
    AST_NO_STORE: assert property (@(posedge CLK) disable iff (SYS_RST)
        CONV_ABORT |-> $stable(loc_t) && $stable(rem_t))
        else $error("aborted conversion changed a stored reading");
    AST_OPEN_SAMPLE: assert property (@(posedge CLK) disable iff (SYS_RST)
        st == tasl_pkg::C_IDLE && next_start |=> open_f == $past(os2))
        else $error("open detector not sampled at conversion start");
    AST_SHORT: assert property (@(posedge CLK) disable iff (SYS_RST)
        st == tasl_pkg::C_CONV && CONV_DONE && !CONV_ABORT && !stby && REMOTE_UNDER
        |=> rem_t == 8'sh80)
        else $error("below-range remote not stored as -128");

    // ***************************************************************
    // limits, alarm and fail-safe
    // ***************************************************************
    logic signed [7:0] lhi, llo, rhi, rlo, lth, rth;
    logic signed [7:0] next_lhi, next_llo, next_rhi, next_rlo, next_lth, next_rth;
    logic [7:0]        hyst, next_hyst, next_cfg, stat, next_rd_hold;
    logic signed [8:0] lrel, rrel;
    logic              c_lhi, c_llo, c_rhi, c_rlo, cond, alert_q, th_l, th_r;
    logic              next_alert, next_th_l, next_th_r, next_rdack, mask;

    // comparisons always look at stored values, so limit writes act at once
    assign c_lhi = seen && loc_t > lhi;
    assign c_llo = seen && loc_t <= llo;
    assign c_rhi = seen && rem_t > rhi;
    assign c_rlo = seen && rem_t <= rlo;
    assign cond = c_lhi | c_llo | c_rhi | c_rlo | open_f;
    assign mask = cfg[`TASL_CFG_MASK];
    assign lrel = 9'(lth) - $signed({1'b0, hyst});
    assign rrel = 9'(rth) - $signed({1'b0, hyst});
    assign stat = {st != tasl_pkg::C_IDLE, c_lhi, c_llo, c_rhi, c_rlo, open_f, th_l, th_r};

    always_comb begin
        {next_cfg, next_hyst} = {cfg, hyst};
        {next_lhi, next_llo, next_rhi, next_rlo} = {lhi, llo, rhi, rlo};
        {next_lth, next_rth} = {lth, rth};
        next_rd_hold = rd_hold;
        next_rdack = rdack;
        // writes are honoured in any power state
        if (wr_hit) begin
            case (wa)
                `TASL_A_CFG: next_cfg = wd;
                `TASL_A_LHI: next_lhi = wd;
                `TASL_A_LLO: next_llo = wd;
                `TASL_A_RHI: next_rhi = wd;
                `TASL_A_RLO: next_rlo = wd;
                `TASL_A_LTHERM: next_lth = wd;
                `TASL_A_RTHERM: next_rth = wd;
                `TASL_A_HYST: next_hyst = wd;
                default: next_cfg = cfg;
            endcase
        end
        if (rd_hit) begin
            case (ra)
                `TASL_A_LOCT: next_rd_hold = loc_t;
                `TASL_A_REMT: next_rd_hold = rem_t;
                `TASL_A_STAT: next_rd_hold = stat;
                `TASL_A_CFG: next_rd_hold = cfg;
                `TASL_A_LHI: next_rd_hold = lhi;
                `TASL_A_LLO: next_rd_hold = llo;
                `TASL_A_RHI: next_rd_hold = rhi;
                `TASL_A_RLO: next_rd_hold = rlo;
                `TASL_A_LTHERM: next_rd_hold = lth;
                `TASL_A_RTHERM: next_rd_hold = rth;
                `TASL_A_HYST: next_rd_hold = hyst;
                default: next_rd_hold = 8'h00;
            endcase
            next_rdack = ~rdack;
        end
        // a won answer clears only with no live cause, masked or not; a live unmasked cause sets; set wins
        next_alert = alert_q;
        if (ara_hit && !cond) begin
            next_alert = 1'b0;
        end
        if (cond && !mask) begin
            next_alert = 1'b1;
        end
        // fail-safe has no mask and releases below limit minus hysteresis
        next_th_l = th_l;
        if (seen && loc_t > lth) begin
            next_th_l = 1'b1;
        end else if (9'(loc_t) < lrel) begin
            next_th_l = 1'b0;
        end
        next_th_r = th_r;
        if (seen && rem_t > rth) begin
            next_th_r = 1'b1;
        end else if (9'(rem_t) < rrel) begin
            next_th_r = 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cfg <= `TASL_RST_CFG;
            hyst <= `TASL_RST_HYST;
            lhi <= `TASL_RST_HI;
            rhi <= `TASL_RST_HI;
            llo <= `TASL_RST_LO;
            rlo <= `TASL_RST_LO;
            lth <= `TASL_RST_OVERTEMP_FAILSAFE_OUT;
            rth <= `TASL_RST_OVERTEMP_FAILSAFE_OUT;
            rd_hold <= 8'h00;
            rdack <= 1'b0;
            alert_q <= 1'b0;
            th_l <= 1'b0;
            th_r <= 1'b0;
            ALERT_OE <= 1'b0;
            ALERT_O <= 1'b0;
            OVERTEMP_FAILSAFE_OUT_OE <= 1'b0;
            OVERTEMP_FAILSAFE_OUT_O <= 1'b0;
        end else begin
            cfg <= next_cfg;
            hyst <= next_hyst;
            lhi <= next_lhi;
            rhi <= next_rhi;
            llo <= next_llo;
            rlo <= next_rlo;
            lth <= next_lth;
            rth <= next_rth;
            rd_hold <= next_rd_hold;
            rdack <= next_rdack;
            alert_q <= next_alert;
            th_l <= next_th_l;
            th_r <= next_th_r;
            ALERT_OE <= next_alert;
            ALERT_O <= 1'b0;
            OVERTEMP_FAILSAFE_OUT_OE <= next_th_l | next_th_r;
            OVERTEMP_FAILSAFE_OUT_O <= 1'b0;
        end
    end

    AST_LOW_EQ: assert property (@(posedge CLK) disable iff (SYS_RST)
        seen && loc_t == llo && !mask |=> ALERT_OE)
        else $error("reading equal to low limit did not alert");
    AST_SHORT_ALERT: assert property (@(posedge CLK) disable iff (SYS_RST)
        seen && rem_t == 8'sh80 && !mask |=> ALERT_OE)
        else $error("shorted remote did not alert");
    AST_HIGH: assert property (@(posedge CLK) disable iff (SYS_RST)
        seen && rem_t > rhi && !mask |=> ALERT_OE)
        else $error("remote above high limit did not alert");
    AST_OPEN_ALERT: assert property (@(posedge CLK) disable iff (SYS_RST)
        open_f && !mask |=> ALERT_OE)
        else $error("open sensor did not alert");
    AST_MASKED: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(ALERT_OE) |-> !$past(mask))
        else $error("alert rose while masked");
    AST_HOLD: assert property (@(posedge CLK) disable iff (SYS_RST)
        ALERT_OE && cond |=> ALERT_OE)
        else $error("alert released with cause still present");
    AST_QUIET: assert property (@(posedge CLK) disable iff (SYS_RST)
        !ALERT_OE && !cond |=> !ALERT_OE)
        else $error("alert raised with readings inside limits");
    AST_DRAIN: assert property (@(posedge CLK) disable iff (SYS_RST)
        !ALERT_O && !OVERTEMP_FAILSAFE_OUT_O)
        else $error("open-drain output driven high");
    AST_OVERTEMP_FAILSAFE_OUT_SET: assert property (@(posedge CLK) disable iff (SYS_RST)
        seen && loc_t > lth |=> OVERTEMP_FAILSAFE_OUT_OE)
        else $error("fail-safe not asserted above local limit");
    AST_OVERTEMP_FAILSAFE_OUT_HOLD: assert property (@(posedge CLK) disable iff (SYS_RST)
        th_r && 9'(rem_t) >= rrel |=> OVERTEMP_FAILSAFE_OUT_OE)
        else $error("fail-safe released inside hysteresis band");
endmodule

// ==== tb/tasl_host.sv ====
// link-side host model: register writes, reads and alert response reads
`timescale 1ns/10ps
module tasl_host (
    input  wire logic       LINK_CLK,
    output logic            WR_STB,
    output logic      [7:0] WR_ADDR,
    output logic      [7:0] WR_DATA,
    output logic            RD_STB,
    output logic      [7:0] RD_ADDR,
    input  wire logic [7:0] RD_DATA,
    input  wire logic       RD_VALID,
    output logic            ARA_LOAD,
    output logic            ARA_BIT_STB,
    output logic            ARA_SDA_BIT,
    output logic            ARA_END,
    input  wire logic       ARA_SDA_OE
);
    initial begin
        {WR_STB, WR_ADDR, WR_DATA, RD_STB, RD_ADDR} = 26'h0;
        {ARA_LOAD, ARA_BIT_STB, ARA_SDA_BIT, ARA_END} = 4'h0;
    end
    task automatic tick();
        @(posedge LINK_CLK);
        #1;
    endtask
    // the trailing gap keeps writes apart while they cross into the system clock
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick();
        {WR_STB, WR_ADDR, WR_DATA} = {1'b1, a, d};
        tick();
        WR_STB = 1'b0;
        repeat (4) tick();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
        int n;
        tick();
        {RD_STB, RD_ADDR} = {1'b1, a};
        tick();
        RD_STB = 1'b0;
        ok = 0;
        for (n = 0; n < 40 && !ok; n++) begin
            @(posedge LINK_CLK);
            ok = (RD_VALID === 1'b1);
            d = RD_DATA;
        end
        #1;
    endtask
    // comp is a rival answering at once; all ones never pulls the pulled-up line low
    task automatic ara(input logic [6:0] comp, output logic [7:0] got);
        int         i;
        logic [7:0] other;
        other = {comp, 1'b1};
        tick();
        ARA_LOAD = 1'b1;
        tick();
        ARA_LOAD = 1'b0;
        ARA_BIT_STB = 1'b1;
        for (i = 7; i >= 0; i--) begin
            got[i] = ~ARA_SDA_OE & other[i];
            ARA_SDA_BIT = got[i];
            tick();
        end
        ARA_BIT_STB = 1'b0;
        ARA_END = 1'b1;
        tick();
        ARA_END = 1'b0;
        repeat (4) tick();
    endtask
endmodule

// ==== tb/tasl_top_test.sv ====
// self-checking bench of the alarm, fail-safe and standby block
`timescale 1ns/10ps
`include "tasl_cfg.svh"
module tasl_top_test;
    // rows: local, remote, remote under range, expected status bits 6..0
    localparam logic [7:0] ROWS [11][4] = '{
        '{8'h20, 8'h30, 8'h00, 8'h00},
        '{8'h00, 8'h30, 8'h00, 8'h20},
        '{8'h01, 8'h30, 8'h00, 8'h00},
        '{8'h56, 8'h30, 8'h00, 8'h42},
        '{8'h4b, 8'h30, 8'h00, 8'h02},
        '{8'h4a, 8'h30, 8'h00, 8'h00},
        '{8'h30, 8'h56, 8'h00, 8'h11},
        '{8'h30, 8'h55, 8'h00, 8'h01},
        '{8'h30, 8'h4a, 8'h00, 8'h00},
        '{8'h30, 8'h40, 8'h01, 8'h08},
        '{8'h30, 8'hff, 8'h00, 8'h08}
    };
    localparam logic [7:0] RST [9][2] = '{'{8'h09, 8'h00}, '{8'h0b, 8'h55}, '{8'h0c, 8'h00},
        '{8'h0d, 8'h55}, '{8'h0e, 8'h00}, '{8'h19, 8'h55}, '{8'h20, 8'h55}, '{8'h21, 8'h0a},
        '{8'h05, 8'h00}};
    logic       clk = 1'b0;
    logic       link_clk = 1'b1;
    logic       sys_rst = 1'b1;
    logic       conv_done = 1'b0;
    logic       remote_under = 1'b0;
    logic       open_det = 1'b0;
    logic [7:0] conv_local = 8'h20;
    logic [7:0] conv_remote = 8'h30;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data, got;
    logic       wr_stb, rd_stb, rd_valid, ara_ack, ara_load, ara_bit_stb, ara_sda_bit;
    logic       ara_end, ara_sda_o, ara_sda_oe, conv_start, conv_abort;
    logic       alert_o, alert_oe, fs_o, fs_oe;
    wire logic  alert_i = ~alert_oe;
    wire logic  fs_i = ~fs_oe;
    int         num_errors = 0, comparisons = 0, starts = 0, aborts = 0, t, s0;

    always #4 clk = ~clk;
    always #7.5 link_clk = ~link_clk;

    tasl_top #(.GAP_CYC(16'h0004), .DEV_ADDR(`TASL_DEV_ADDR)) tasl_top_inst (
        .CLK(clk), .SYS_RST(sys_rst), .LINK_CLK(link_clk), .WR_STB(wr_stb), .WR_ADDR(wr_addr),
        .WR_DATA(wr_data), .RD_STB(rd_stb), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
        .RD_VALID(rd_valid), .ARA_ACK(ara_ack), .ARA_LOAD(ara_load), .ARA_BIT_STB(ara_bit_stb),
        .ARA_SDA_BIT(ara_sda_bit), .ARA_END(ara_end), .ARA_SDA_O(ara_sda_o),
        .ARA_SDA_OE(ara_sda_oe), .CONV_START(conv_start), .CONV_ABORT(conv_abort),
        .CONV_DONE(conv_done), .CONV_LOCAL(conv_local), .CONV_REMOTE(conv_remote),
        .REMOTE_UNDER(remote_under), .OPEN_DET(open_det), .ALERT_I(alert_i), .ALERT_O(alert_o),
        .ALERT_OE(alert_oe), .OVERTEMP_FAILSAFE_OUT_I(fs_i), .OVERTEMP_FAILSAFE_OUT_O(fs_o),
        .OVERTEMP_FAILSAFE_OUT_OE(fs_oe));
    tasl_host tasl_host_inst (
        .LINK_CLK(link_clk), .WR_STB(wr_stb), .WR_ADDR(wr_addr), .WR_DATA(wr_data),
        .RD_STB(rd_stb), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .ARA_LOAD(ara_load), .ARA_BIT_STB(ara_bit_stb), .ARA_SDA_BIT(ara_sda_bit),
        .ARA_END(ara_end), .ARA_SDA_OE(ara_sda_oe));

    // converter stand-in: answers each start after a long conversion, so aborts can land
    always begin
        @(posedge clk);
        if (conv_start === 1'b1) begin
            repeat (20) @(posedge clk);
            #1 conv_done = 1'b1;
            @(posedge clk);
            #1 conv_done = 1'b0;
        end
    end
    always @(posedge clk) begin
        starts <= starts + int'(conv_start === 1'b1);
        aborts <= aborts + int'(conv_abort === 1'b1);
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic final_report();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic timeout();
        num_errors++;
        $display("[ERR] %0t no answer in time", $time);
        final_report();
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic convs(input int n);
        int k;
        repeat (n) begin
            for (k = 0; k < 100 && conv_done !== 1'b1; k++) @(posedge clk);
            if (k == 100) timeout();
            @(posedge clk);
        end
        repeat (8) @(posedge clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        bit         ok;
        tasl_host_inst.rd(a, d, ok);
        if (!ok) timeout();
        chk(d & m, e);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        #1 sys_rst = 1'b0;
        foreach (ROWS[i]) begin
            step();
            {conv_local, conv_remote, remote_under} = {ROWS[i][0], ROWS[i][1], ROWS[i][2][0]};
            convs(2);
            rdchk(`TASL_A_STAT, 8'h7f, ROWS[i][3]);
            chk({7'h0, fs_oe}, {7'h0, |ROWS[i][3][1:0]});
            for (t = 0; t < 3 && alert_i === 1'b0; t++) tasl_host_inst.ara(7'h7f, got);
            chk({7'h0, alert_oe}, {7'h0, |ROWS[i][3][6:2]});
        end
        foreach (RST[i]) rdchk(RST[i][0], 8'hff, RST[i][1]);
        // a lost answer must leave the alert standing
        step();
        conv_local = 8'h00;
        convs(2);
        chk({7'h0, ara_ack}, 8'h01);
        tasl_host_inst.ara(7'h00, got);
        chk(got, 8'h01);
        step();
        // both channels back inside limits, so only the answer may release alert
        {conv_local, conv_remote} = {8'h20, 8'h30};
        convs(2);
        chk({7'h0, alert_oe}, 8'h01);
        tasl_host_inst.ara(7'h4d, got);
        chk(got, {`TASL_DEV_ADDR, 1'b1});
        chk({5'h0, alert_o, ara_sda_o, alert_oe}, 8'h00);
        tasl_host_inst.wr(`TASL_A_CFG, 8'h80);
        step();
        conv_local = 8'h56;
        convs(2);
        chk({6'h0, alert_oe, fs_oe}, 8'h01);
        step();
        conv_local = 8'h20;
        convs(2);
        tasl_host_inst.wr(`TASL_A_CFG, 8'h00);
        // standby lands while a conversion is under way
        for (t = 0; t < 100 && conv_start !== 1'b1; t++) @(posedge clk);
        if (t == 100) timeout();
        #1 conv_local = 8'h11;
        tasl_host_inst.wr(`TASL_A_CFG, 8'h40);
        s0 = starts;
        repeat (60) @(posedge clk);
        chk(8'(aborts), 8'h01);
        chk(8'(starts - s0), 8'h00);
        rdchk(`TASL_A_LOCT, 8'hff, 8'h20);
        tasl_host_inst.wr(`TASL_A_LHI, 8'h10);
        repeat (8) @(posedge clk);
        chk({7'h0, alert_oe}, 8'h01);
        tasl_host_inst.wr(`TASL_A_LHI, 8'h55);
        step();
        {open_det, remote_under, conv_local} = {2'b11, 8'h33};
        tasl_host_inst.wr(`TASL_A_RLO, 8'h80);
        s0 = starts;
        tasl_host_inst.wr(`TASL_A_ONESHOT, 8'h5a);
        convs(1);
        repeat (60) @(posedge clk);
        chk(8'(starts - s0), 8'h01);
        rdchk(`TASL_A_LOCT, 8'hff, 8'h33);
        rdchk(`TASL_A_REMT, 8'hff, 8'h80);
        rdchk(`TASL_A_STAT, 8'h0c, 8'h0c);
        // mid-run reset: outputs drop and standby is left
        #1 sys_rst = 1'b1;
        repeat (4) @(posedge clk);
        chk({5'h0, alert_oe, fs_oe, conv_start}, 8'h00);
        #1 sys_rst = 1'b0;
        rdchk(`TASL_A_CFG, 8'hff, 8'h00);
        final_report();
    end
endmodule
